// >>> eprs_cfg.svh
`ifndef EPRS_CFG_SVH
`define EPRS_CFG_SVH
// clock rate and pulse timing
`define EPRS_CLK_HZ 100000000
`define EPRS_PULSE_US 1000
`define EPRS_PULSE_CYC ((`EPRS_CLK_HZ / 1000000) * `EPRS_PULSE_US)
`define EPRS_MAX_PULSES 25
`define EPRS_OVER_MULT 3
// set-up and settle time around pin changes, in microseconds
`define EPRS_SETUP_US 2
`define EPRS_SETUP_CYC ((`EPRS_CLK_HZ / 1000000) * `EPRS_SETUP_US)
// supply select codes
`define EPRS_SUP_READ 2'h0
`define EPRS_SUP_PROG 2'h1
`define EPRS_SUP_VERIFY5 2'h2
`endif

// >>> eprs_pkg.sv
package eprs_pkg;
    // controller states
    typedef enum logic [3:0] {
        EPRS_IDLE, EPRS_SETUP, EPRS_PULSE, EPRS_VSET, EPRS_VCHK,
        EPRS_OVER, EPRS_NEXT, EPRS_RSET, EPRS_RCHK, EPRS_IDSET, EPRS_IDCHK, EPRS_DONE
    } eprs_state_type;
endpackage

// >>> eprs_prog.sv
`timescale 1ns/10ps
`include "eprs_cfg.svh"
// Overview of operation
// RULE_01: initial program pulse is one millisecond
// RULE_02: overprogram pulse lasts three times X ms
// RULE_03: at most 25 initial pulses per byte
// RULE_04: program and verify at 6V, 12.5V
// RULE_05: final readback of all bytes at 5V
// RULE_06: only low chip select device gets programmed
// RULE_07: high chip select inhibits programming
// RULE_08: verify: gate, select low, strobe high
// RULE_09: verify result drives pulse loop
// RULE_10: raise identify line high voltage for codes
// RULE_11: byte select picks maker or type code
// RULE_12: other address lines low during identify
// RULE_13: erased cells read ones, program clears bits
// RULE_14: program with select and strobe low
// RULE_15: select high keeps device data floating
// RULE_16: failing byte after 25 pulses aborts device
module eprs_prog import eprs_pkg::*; #(
    parameter int ADDR_W = 13,
    parameter int PULSE_CYC = `EPRS_PULSE_CYC,
    parameter int SETUP_CYC = `EPRS_SETUP_CYC,
    parameter int MAX_PULSES = `EPRS_MAX_PULSES
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // command port
    input wire logic i_start_prog,
    input wire logic i_start_id,
    input wire logic [ADDR_W-1:0] i_last_addr,
    input wire logic [7:0] i_src_data,
    // source data address and status
    output logic [ADDR_W-1:0] o_src_addr,
    output logic o_busy,
    output logic o_done,
    output logic o_fail,
    output logic o_cmp_fail,
    output logic [7:0] o_maker_code,
    output logic [7:0] o_type_code,
    // device pins
    output logic [ADDR_W-1:0] o_addr,
    output logic o_hv_identify_line,
    output logic o_chip_sel_n,
    output logic o_out_gate_n,
    output logic o_program_strobe_n,
    output logic [7:0] o_data_out,
    output logic o_data_oe_n,
    input wire logic [7:0] i_data_in,
    output logic [1:0] o_supply_sel
);
    // all controller state in one record
    typedef struct packed {
        eprs_state_type st;
        logic [ADDR_W-1:0] addr;
        logic [31:0] timer;
        logic [4:0] x_cnt;
        logic [7:0] wdata;
        logic id_sel;
        logic hv;
        logic cs_n;
        logic oe_n;
        logic pgm_n;
        logic doe_n;
        logic [1:0] sup;
        logic busy;
        logic done;
        logic fail;
        logic cmp_fail;
        logic [7:0] maker;
        logic [7:0] dtype;
    } eprs_regs_type;

    eprs_regs_type r, n;

    // next-state logic
    always_comb begin
        n = r;
        n.done = 1'b0;
        if (r.timer != 32'h0) begin
            n.timer = r.timer - 32'h1; // waiting on a pulse or set-up
        end else begin
            case (r.st)
                EPRS_IDLE: begin
                    n.cs_n = 1'b1; // standby, device floats [RULE_15]
                    n.oe_n = 1'b1;
                    n.pgm_n = 1'b1;
                    n.doe_n = 1'b1;
                    n.hv = 1'b0;
                    n.sup = `EPRS_SUP_READ;
                    if (i_start_prog) begin
                        n.busy = 1'b1;
                        n.fail = 1'b0;
                        n.cmp_fail = 1'b0;
                        n.addr = '0;
                        n.x_cnt = 5'h0;
                        n.sup = `EPRS_SUP_PROG; // 6V and 12.5V [RULE_04]
                        n.timer = 32'(SETUP_CYC);
                        n.st = EPRS_SETUP;
                    end else if (i_start_id) begin
                        n.busy = 1'b1;
                        n.addr = '0; // all other lines low [RULE_12]
                        n.id_sel = 1'b0;
                        n.hv = 1'b1; // identify voltage on [RULE_10]
                        n.cs_n = 1'b0;
                        n.oe_n = 1'b0;
                        n.timer = 32'(SETUP_CYC);
                        n.st = EPRS_IDCHK;
                    end
                end
                EPRS_SETUP: begin
                    // present byte and select low together, then strobe low [RULE_14]
                    n.wdata = i_src_data;
                    n.doe_n = 1'b0;
                    n.oe_n = 1'b1;
                    n.cs_n = 1'b0; // only this device selected [RULE_06] [RULE_07]
                    n.st = EPRS_PULSE;
                    n.timer = 32'(SETUP_CYC);
                end
                EPRS_PULSE: begin
                    if (r.pgm_n) begin
                        n.pgm_n = 1'b0;
                        n.x_cnt = r.x_cnt + 5'h1; // count per location [RULE_03]
                        n.timer = 32'(PULSE_CYC - 1); // one millisecond [RULE_01]
                    end else begin
                        n.pgm_n = 1'b1;
                        n.doe_n = 1'b1;
                        n.timer = 32'(SETUP_CYC);
                        n.st = EPRS_VSET;
                    end
                end
                EPRS_VSET: begin
                    n.oe_n = 1'b0; // verify mode [RULE_08]
                    n.timer = 32'(SETUP_CYC);
                    n.st = EPRS_VCHK;
                end
                EPRS_VCHK: begin
                    n.oe_n = 1'b1;
                    if (i_data_in == r.wdata) begin
                        // byte verified: overprogram pulse [RULE_09] [RULE_02]
                        n.doe_n = 1'b0;
                        n.st = EPRS_OVER;
                        n.timer = 32'(SETUP_CYC);
                    end else if (r.x_cnt >= 5'(MAX_PULSES)) begin
                        n.fail = 1'b1; // give up on device [RULE_16]
                        n.st = EPRS_DONE;
                    end else begin
                        n.st = EPRS_SETUP; // another pulse [RULE_09]
                    end
                end
                EPRS_OVER: begin
                    if (r.pgm_n) begin
                        n.pgm_n = 1'b0;
                        n.timer = 32'(`EPRS_OVER_MULT * PULSE_CYC) * 32'(r.x_cnt) - 32'h1; // [RULE_02]
                    end else begin
                        n.pgm_n = 1'b1;
                        n.doe_n = 1'b1;
                        n.timer = 32'(SETUP_CYC);
                        n.st = EPRS_NEXT;
                    end
                end
                EPRS_NEXT: begin
                    n.x_cnt = 5'h0;
                    if (r.addr == i_last_addr) begin
                        n.addr = '0;
                        n.sup = `EPRS_SUP_VERIFY5; // readback at 5V [RULE_05]
                        n.timer = 32'(SETUP_CYC);
                        n.st = EPRS_RSET;
                    end else begin
                        n.addr = r.addr + 1'b1;
                        n.st = EPRS_SETUP;
                    end
                end
                EPRS_RSET: begin
                    n.oe_n = 1'b0;
                    n.timer = 32'(SETUP_CYC);
                    n.st = EPRS_RCHK;
                end
                EPRS_RCHK: begin
                    n.oe_n = 1'b1;
                    if (i_data_in != i_src_data) begin
                        n.cmp_fail = 1'b1; // unprogrammed ones stay visible [RULE_13]
                    end
                    if (r.addr == i_last_addr) begin
                        n.st = EPRS_DONE;
                    end else begin
                        n.addr = r.addr + 1'b1;
                        n.st = EPRS_RSET;
                    end
                end
                EPRS_IDCHK: begin
                    // byte select chooses code [RULE_11]
                    if (!r.id_sel) begin
                        n.maker = i_data_in;
                        n.id_sel = 1'b1;
                        n.timer = 32'(SETUP_CYC);
                    end else begin
                        n.dtype = i_data_in;
                        n.id_sel = 1'b0;
                        n.st = EPRS_DONE;
                    end
                end
                default: begin
                    // finish and return pins to idle
                    n.busy = 1'b0;
                    n.done = 1'b1;
                    n.hv = 1'b0;
                    n.cs_n = 1'b1;
                    n.oe_n = 1'b1;
                    n.pgm_n = 1'b1;
                    n.doe_n = 1'b1;
                    n.sup = `EPRS_SUP_READ;
                    n.st = EPRS_IDLE;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            r <= '0;
            r.st <= EPRS_IDLE;
            r.cs_n <= 1'b1;
            r.oe_n <= 1'b1;
            r.pgm_n <= 1'b1;
            r.doe_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // outputs straight from the record, except o_addr, which ORs id_sel into bit 0
    always_comb begin
        o_src_addr = r.addr;
        o_busy = r.busy;
        o_done = r.done;
        o_fail = r.fail;
        o_cmp_fail = r.cmp_fail;
        o_maker_code = r.maker;
        o_type_code = r.dtype;
        o_addr = r.addr | {{(ADDR_W-1){1'b0}}, r.id_sel};
        o_hv_identify_line = r.hv;
        o_chip_sel_n = r.cs_n;
        o_out_gate_n = r.oe_n;
        o_program_strobe_n = r.pgm_n;
        o_data_out = r.wdata;
        o_data_oe_n = r.doe_n;
        o_supply_sel = r.sup;
    end
endmodule

// >>> eprs_prog_properties.sv
`timescale 1ns/10ps
module eprs_prog_chk #(
    parameter int ADDR_W = 13,
    parameter int PULSE_CYC = 20,
    parameter int MAX_PULSES = 25
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // watched pins and status
    input wire logic o_program_strobe_n,
    input wire logic o_chip_sel_n,
    input wire logic o_out_gate_n,
    input wire logic o_data_oe_n,
    input wire logic o_hv_identify_line,
    input wire logic o_fail,
    input wire logic [1:0] o_supply_sel,
    input wire logic [ADDR_W-1:0] o_addr
);
    int w_r; // cycles the strobe has been low
    int x_r; // initial pulses given to this byte
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    // measure pulse widths and count initial pulses per byte
    always_ff @(posedge i_ref_clk) begin
        w_r <= (!i_rst_n || o_program_strobe_n) ? 0 : w_r + 1;
        if (!i_rst_n || $changed(o_addr)) begin
            x_r <= 0;
        end else if ($rose(o_program_strobe_n)) begin
            x_r <= (w_r == PULSE_CYC) ? x_r + 1 : 0;
        end
    end
    sequence s_pulse_end;
        $rose(o_program_strobe_n);
    endsequence
    property p_init_len;
        s_pulse_end |-> (w_r == PULSE_CYC || w_r >= 3 * PULSE_CYC);
    endproperty
    a_init_len: assert property (p_init_len) else $error("strobe pulse width wrong");
    property p_over_len;
        s_pulse_end ##0 (w_r > PULSE_CYC) |-> w_r == 3 * x_r * PULSE_CYC;
    endproperty
    a_over_len: assert property (p_over_len) else $error("overprogram width wrong");
    property p_max;
        x_r <= MAX_PULSES;
    endproperty
    a_max: assert property (p_max) else $error("too many initial pulses");
    property p_prog_sup;
        !o_program_strobe_n |-> o_supply_sel == 2'h1;
    endproperty
    a_prog_sup: assert property (p_prog_sup) else $error("pulse without program supply");
    property p_prog_pins;
        !o_program_strobe_n |-> !o_data_oe_n && o_out_gate_n && !o_chip_sel_n;
    endproperty
    a_prog_pins: assert property (p_prog_pins) else $error("program pins wrong");
    property p_no_clash;
        !o_out_gate_n |-> o_data_oe_n && o_program_strobe_n;
    endproperty
    a_no_clash: assert property (p_no_clash) else $error("data driven while gate low");
    property p_id_addr;
        o_hv_identify_line |-> o_addr[ADDR_W-1:1] == 0 && o_supply_sel == 2'h0;
    endproperty
    a_id_addr: assert property (p_id_addr) else $error("identify address wrong");
    property p_readback;
        o_supply_sel == 2'h2 |-> o_program_strobe_n && !o_hv_identify_line;
    endproperty
    a_readback: assert property (p_readback) else $error("pulse during readback");
    property p_fail;
        $rose(o_fail) |-> x_r == MAX_PULSES;
    endproperty
    a_fail: assert property (p_fail) else $error("fail before pulse limit");
endmodule
bind eprs_prog eprs_prog_chk #(.ADDR_W(ADDR_W), .PULSE_CYC(PULSE_CYC), .MAX_PULSES(MAX_PULSES)) i_chk (
    .i_ref_clk, .i_rst_n, .o_program_strobe_n, .o_chip_sel_n, .o_out_gate_n, .o_data_oe_n,
    .o_hv_identify_line, .o_fail, .o_supply_sel, .o_addr);

// >>> eprs_dev_model.sv
`timescale 1ns/10ps
module eprs_dev_model #(
    parameter logic [7:0] MAKER = 8'h5a, // arbitrary value
    parameter logic [7:0] KIND = 8'ha6 // arbitrary value
) (
    // pins from the controller, plus clock and the testbench bad-read switch
    input wire logic i_ref_clk,
    input wire logic [12:0] i_addr,
    input wire logic i_hv,
    input wire logic i_cs_n,
    input wire logic i_oe_n,
    input wire logic i_pgm_n,
    input wire logic [7:0] i_din,
    input wire logic i_din_oe_n,
    input wire logic [1:0] i_sup,
    input wire logic i_bad_rd,
    // data back to the controller
    output logic [7:0] o_dq
);
    logic [7:0] mem [8192]; // cell array
    int cnt [8192]; // pulses seen per byte
    int need [8192]; // pulses a byte needs
    logic [7:0] last = 8'h00; // last driven byte
    logic drv; // device drives data
    logic [7:0] val; // byte offered
    assign drv = !i_cs_n && !i_oe_n && i_pgm_n;
    assign val = i_hv ? (i_addr[0] ? KIND : MAKER) : mem[i_addr] ^ {7'h0, i_bad_rd && i_sup == 2'h2};
    assign o_dq = drv ? val : ~last; // released lines show no stale value
    always @(posedge i_ref_clk) if (drv) last <= val;
    // a pulse counts at its leading edge, only with select low and high supply
    always @(negedge i_pgm_n) begin
        if (!i_cs_n && i_sup == 2'h1 && !i_din_oe_n) begin
            cnt[i_addr] += 1;
            if (cnt[i_addr] >= need[i_addr]) mem[i_addr] &= i_din;
        end
    end
endmodule

// >>> eprom_program_signature_seq_test.sv
`timescale 1ns/10ps
module eprom_program_signature_seq_test;
    logic i_ref_clk = 0, i_rst_n = 0, start_prog = 0, start_id = 0, bad_rd = 0;
    logic [12:0] last_addr = 13'h0, src_addr, addr;
    logic busy, done, fail, cmp_fail, hv, cs_n, oe_n, pgm_n, dout_oe_n;
    logic [7:0] maker, kind, dout, din;
    logic [7:0] src [8];
    logic [1:0] sup;
    int fail_count = 0, num_checks = 0;
    initial forever #5 i_ref_clk = ~i_ref_clk;
    eprs_prog #(.PULSE_CYC(20), .SETUP_CYC(2)) i_dut (.i_ref_clk, .i_rst_n, .i_start_prog(start_prog),
        .i_start_id(start_id), .i_last_addr(last_addr), .i_src_data(src[src_addr[2:0]]),
        .o_src_addr(src_addr), .o_busy(busy), .o_done(done), .o_fail(fail), .o_cmp_fail(cmp_fail),
        .o_maker_code(maker), .o_type_code(kind), .o_addr(addr), .o_hv_identify_line(hv),
        .o_chip_sel_n(cs_n), .o_out_gate_n(oe_n), .o_program_strobe_n(pgm_n), .o_data_out(dout),
        .o_data_oe_n(dout_oe_n), .i_data_in(din), .o_supply_sel(sup));
    eprs_dev_model i_mod (.i_ref_clk, .i_addr(addr), .i_hv(hv), .i_cs_n(cs_n), .i_oe_n(oe_n),
        .i_pgm_n(pgm_n), .i_din(dout), .i_din_oe_n(dout_oe_n), .i_sup(sup), .i_bad_rd(bad_rd), .o_dq(din));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // programmed bytes hold the source, the rest stay erased
    function automatic logic [7:0] exp_cell(input int a, input int last);
        return (a <= last) ? src[a] : 8'hff;
    endfunction
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // erase the model and give each byte a random pulse need
    task automatic erase;
        for (int a = 0; a < 8192; a++) begin
            i_mod.mem[a] = 8'hff;
            i_mod.cnt[a] = 0;
            i_mod.need[a] = 1 + $urandom % 4;
        end
    endtask
    // one start pulse, then a bounded wait for busy to drop
    task automatic run(input logic id, input logic [12:0] last);
        last_addr = last;
        start_id = id;
        start_prog = !id;
        @(negedge i_ref_clk);
        start_id = 0;
        start_prog = 0;
        @(negedge i_ref_clk);
        for (int n = 0; busy !== 1'b0; n++) begin
            if (n > 30000) begin
                fail_count++;
                $display("BAD busy expected %h seen %h", 1'b0, busy);
                end_sim;
            end
            @(negedge i_ref_clk);
        end
        chk("done", 8'h01, {7'h0, done});
    endtask
    initial begin
        void'($urandom(14010));
        erase;
        for (int a = 0; a < 8; a++) src[a] = $urandom;
        src[0] = 8'h00;
        src[1][7] = 1'b0; // never erased value, so the over-limit byte cannot verify
        repeat (8) @(negedge i_ref_clk);
        i_rst_n = 1;
        run(1, 13'h0);
        chk("maker", 8'h5a, maker);
        chk("type", 8'ha6, kind);
        i_mod.need[2] = 25; // deepest byte still allowed
        run(0, 13'h3);
        for (int a = 0; a < 5; a++) chk("cell", exp_cell(a, 3), i_mod.mem[a]);
        chk("status", 8'h00, {6'h0, fail, cmp_fail});
        erase;
        i_mod.need[1] = 26; // one past the limit
        run(0, 13'h3);
        chk("status", 8'h02, {6'h0, fail, cmp_fail});
        chk("cell2", 8'hff, i_mod.mem[2]);
        erase;
        bad_rd = 1;
        run(0, 13'h1);
        bad_rd = 0;
        chk("status", 8'h01, {6'h0, fail, cmp_fail});
        end_sim;
    end
endmodule
